// ===== logic/pss_defs.svh
// Purpose: Constants of the power sequence supervisor.
// Assumes: 125 MHz core clock, register port with 8-bit byte addresses.
// Notes: Times are in microseconds; cycle counts derive from the clock rate.
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
// ==========================================================
// Timing
`define PSS_CLK_MHZ 125
`define PSS_TICK_CYC (`PSS_CLK_MHZ * 1)
`define PSS_CAL_US 500
`define PSS_OV_US 5000
`define PSS_PG_US 20000
`define PSS_STEP_US 100
// ==========================================================
// Register offsets
`define PSS_CTRL_OFS 8'h00
`define PSS_STATE_OFS 8'h04
`define PSS_IRQ_OFS 8'h08
`define PSS_MASK_OFS 8'h0C
`define PSS_TIM_OFS 8'h10
`define PSS_TIM_NUM 12
// ==========================================================
// Fields and reset values
`define PSS_CTRL_OT_HIC 0
`define PSS_CTRL_OV_HIC 1
`define PSS_IRQ_OT 0
`define PSS_IRQ_OV 1
`define PSS_IRQ_PG 2
`define PSS_CTRL_RST 2'h0
`define PSS_TIM_RST 8'h01
`endif

// ===== logic/pss_pkg.sv
// Purpose: Types of the power sequence supervisor.
// Assumes: Nothing beyond the defs header.
// Notes: State order sets the state code read back in the state register.
package pss_pkg;
	typedef enum {ST_CAL, ST_OFF, ST_DLY, ST_LAST, ST_PGD, ST_ON, ST_FLT} pss_state_e;
endpackage

// ===== logic/pss_top.sv
// Purpose: Power-on sequencing, fault handling and power-good timing.
// Assumes: rst_n is low while the internal analog supply is below threshold.
// Notes: One microsecond tick enable drives every interval counter.
`timescale 1ns/1ps
`include "pss_defs.svh"

// How it works
// - With enable high, channels switch on one by one in configured order.
// - Start-up calibration takes 500 us; register writes are ignored meanwhile.
// - Sequence pin picks order; the first five of twelve timing registers set the step delays, also of a running sequence.
// - Loss of internal analog supply returns all registers to defaults.
// - Register interface works whenever both supplies are present.
// - Over-temperature shuts every channel down.
// - In restart mode, cooling below hysteresis reruns the power-on sequence.
// - Input over-voltage switches every channel off 5 ms after detection.
// - In restart mode, input dropping below hysteresis reruns the sequence.
// - Enable low shuts down; enable high again reruns the sequence from the first channel.
// - Last channel at 90 percent starts a 20 ms power-good delay.
// - After the delay power good is released until enable low or a fault.
// - Power good is open drain: only pulled low or released.
module pss_top #(
	parameter int NCH = 5,
	parameter int CAL_TICKS = `PSS_CAL_US,
	parameter int OV_TICKS = `PSS_OV_US,
	parameter int PG_TICKS = `PSS_PG_US
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// Pins and detectors
	input wire logic chip_enable_pin,
	input wire logic sequence_select_pin,
	input wire logic overtemp_trip,
	input wire logic overvolt_trip,
	input wire logic [NCH-1:0] chan_good,
	// Channel enables and power good
	output logic [NCH-1:0] chan_en,
	output logic power_good_output_o,
	output logic power_good_output_oe
);

	typedef struct packed {
		pss_pkg::pss_state_e st;
		logic [2:0] step;
		logic [15:0] cnt;
		logic [15:0] ovcnt;
		logic [7:0] pres;
		logic en1, en2, sq1, sq2, ot1, ot2, ov1, ov2;
		logic [NCH-1:0] gd1;
		logic [NCH-1:0] gd2;
		logic ord;
		logic flt_ot, flt_ov;
		logic [1:0] ctrl;
		logic [2:0] irq;
		logic [2:0] mask;
		logic [11:0][7:0] tim;
		logic [31:0] rdata;
		logic [NCH-1:0] chan;
		logic pg;
	} pss_state_s;

	pss_state_s r_reg;
	pss_state_s r_next;
	logic tick;
	logic active;
	logic [2:0] idx;
	logic [2:0] last_idx;
	logic [2:0] ev;
	logic [15:0] dly;

	// ==========================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		ev = 3'h0;
		tick = (r_reg.pres == 8'(`PSS_TICK_CYC - 1));
		r_next.pres = tick ? 8'h00 : r_reg.pres + 8'h01;
		// Pins cross from outside through two flops
		r_next.en1 = chip_enable_pin;
		r_next.en2 = r_reg.en1;
		r_next.sq1 = sequence_select_pin;
		r_next.sq2 = r_reg.sq1;
		r_next.ot1 = overtemp_trip;
		r_next.ot2 = r_reg.ot1;
		r_next.ov1 = overvolt_trip;
		r_next.ov2 = r_reg.ov1;
		r_next.gd1 = chan_good;
		r_next.gd2 = r_reg.gd1;
		active = (r_reg.st == pss_pkg::ST_DLY) || (r_reg.st == pss_pkg::ST_LAST) ||
			(r_reg.st == pss_pkg::ST_PGD) || (r_reg.st == pss_pkg::ST_ON);
		idx = r_reg.ord ? 3'(NCH - 1) - r_reg.step : r_reg.step;
		last_idx = r_reg.ord ? 3'h0 : 3'(NCH - 1);
		dly = 16'(r_reg.tim[r_reg.step]) * 16'(`PSS_STEP_US);

		// reads answered in any state while out of reset
		r_next.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`PSS_CTRL_OFS: r_next.rdata = {30'h0, r_reg.ctrl};
				`PSS_STATE_OFS: r_next.rdata = {16'h0, r_reg.pg, r_reg.ord,
					r_reg.flt_ov, r_reg.flt_ot, 3'(r_reg.st), 1'b0, 8'(r_reg.chan)};
				`PSS_IRQ_OFS: r_next.rdata = {29'h0, r_reg.irq};
				`PSS_MASK_OFS: r_next.rdata = {29'h0, r_reg.mask};
				default: begin
					if (reg_addr >= `PSS_TIM_OFS && reg_addr < 8'h40 && reg_addr[1:0] == 2'h0) begin
						r_next.rdata = {24'h0, r_reg.tim[4'(reg_addr[5:2] - 4'h4)]};
					end
				end
			endcase
		end

		// writes have no effect until calibration is done
		// timing registers change the step delays at once, also in a running sequence
		if (reg_wr && r_reg.st != pss_pkg::ST_CAL) begin
			case (reg_addr)
				`PSS_CTRL_OFS: r_next.ctrl = reg_wdata[1:0];
				`PSS_MASK_OFS: r_next.mask = reg_wdata[2:0];
				default: begin
					if (reg_addr >= `PSS_TIM_OFS && reg_addr < 8'h40 && reg_addr[1:0] == 2'h0) begin
						r_next.tim[4'(reg_addr[5:2] - 4'h4)] = reg_wdata[7:0];
					end
				end
			endcase
		end

		// over-voltage interval counted in reference ticks
		if (r_reg.ov2 && active) begin
			if (tick) begin
				r_next.ovcnt = r_reg.ovcnt + 16'h0001;
			end
		end else begin
			r_next.ovcnt = 16'h0000;
		end

		case (r_reg.st)
			pss_pkg::ST_CAL: begin
				if (tick) begin
					r_next.cnt = r_reg.cnt + 16'h0001;
				end
				if (r_reg.cnt == 16'(CAL_TICKS - 1) && tick) begin
					r_next.st = pss_pkg::ST_OFF;
					r_next.cnt = 16'h0000;
				end
			end
			pss_pkg::ST_OFF: begin
				if (r_reg.en2) begin
					r_next.st = pss_pkg::ST_DLY;
					r_next.step = 3'h0;
					r_next.cnt = 16'h0000;
					r_next.ord = r_reg.sq2;
				end
			end
			pss_pkg::ST_DLY: begin
				// each step waits its delay, then turns one channel on
				if (tick) begin
					r_next.cnt = r_reg.cnt + 16'h0001;
				end
				if (r_reg.cnt >= dly) begin
					r_next.chan[idx] = 1'b1;
					r_next.cnt = 16'h0000;
					if (r_reg.step == 3'(NCH - 1)) begin
						r_next.st = pss_pkg::ST_LAST;
					end else begin
						r_next.step = r_reg.step + 3'h1;
					end
				end
			end
			pss_pkg::ST_LAST: begin
				// last channel in regulation starts the delay
				if (r_reg.gd2[last_idx]) begin
					r_next.st = pss_pkg::ST_PGD;
					r_next.cnt = 16'h0000;
				end
			end
			pss_pkg::ST_PGD: begin
				if (tick) begin
					r_next.cnt = r_reg.cnt + 16'h0001;
				end
				if (r_reg.cnt == 16'(PG_TICKS - 1) && tick) begin
					r_next.st = pss_pkg::ST_ON;
					r_next.pg = 1'b1;
					ev[`PSS_IRQ_PG] = 1'b1;
				end
			end
			pss_pkg::ST_ON: begin
				r_next.pg = 1'b1;
			end
			pss_pkg::ST_FLT: begin
				// restart when the fault clears in restart mode
				if ((r_reg.flt_ot && r_reg.ctrl[`PSS_CTRL_OT_HIC] && !r_reg.ot2) ||
					(r_reg.flt_ov && r_reg.ctrl[`PSS_CTRL_OV_HIC] && !r_reg.ov2)) begin
					r_next.st = pss_pkg::ST_OFF;
					r_next.flt_ot = 1'b0;
					r_next.flt_ov = 1'b0;
				end
				// otherwise held off until enable drops
			end
			default: begin
				r_next.st = pss_pkg::ST_OFF;
			end
		endcase

		if (active && r_reg.ot2) begin
			r_next.st = pss_pkg::ST_FLT;
			r_next.flt_ot = 1'b1;
			ev[`PSS_IRQ_OT] = 1'b1;
		end
		// over-voltage trips when its delay runs out
		if (active && r_reg.ov2 && r_reg.ovcnt == 16'(OV_TICKS - 1) && tick) begin
			r_next.st = pss_pkg::ST_FLT;
			r_next.flt_ov = 1'b1;
			ev[`PSS_IRQ_OV] = 1'b1;
		end
		// enable low shuts everything down and clears a fault
		if (!r_reg.en2 && r_reg.st != pss_pkg::ST_CAL) begin
			r_next.st = pss_pkg::ST_OFF;
			r_next.flt_ot = 1'b0;
			r_next.flt_ov = 1'b0;
		end
		if (r_next.st == pss_pkg::ST_OFF || r_next.st == pss_pkg::ST_FLT) begin
			r_next.chan = '0;
			r_next.pg = 1'b0;
		end

		// Sticky events; a new event beats a write-one clear
		r_next.irq = r_reg.irq;
		if (reg_wr && reg_addr == `PSS_IRQ_OFS && r_reg.st != pss_pkg::ST_CAL) begin
			r_next.irq = r_reg.irq & ~reg_wdata[2:0];
		end
		r_next.irq = r_next.irq | ev;
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.st <= pss_pkg::ST_CAL;
			r_reg.ctrl <= `PSS_CTRL_RST;
			r_reg.tim <= {`PSS_TIM_NUM{`PSS_TIM_RST}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata = r_reg.rdata;
	assign irq = |(r_reg.irq & r_reg.mask);
	assign chan_en = r_reg.chan;
	assign power_good_output_o = 1'b0;
	assign power_good_output_oe = !r_reg.pg;

	// ==========================================================
	// Checks
	cal_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_wr && r_reg.st == pss_pkg::ST_CAL |=> $stable(r_reg.ctrl) && $stable(r_reg.tim))
		else $error("write took effect during calibration");
	ot_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		active && r_reg.ot2 |=> chan_en == '0 && power_good_output_oe)
		else $error("channels left on after over-temperature");
	ov_trip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(r_reg.flt_ov) |-> $past(r_reg.ovcnt) == 16'(OV_TICKS - 1) && chan_en == '0)
		else $error("over-voltage trip at wrong count");
	en_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!r_reg.en2 && r_reg.st != pss_pkg::ST_CAL |=> chan_en == '0 && !r_reg.pg)
		else $error("enable low did not shut down");
	pg_delay_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(r_reg.pg) |-> $past(r_reg.st) == pss_pkg::ST_PGD &&
		$past(r_reg.cnt) == 16'(PG_TICKS - 1))
		else $error("power good released without full delay");
	pg_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r_reg.pg && r_reg.en2 && !r_reg.ot2 && !r_reg.ov2 |=> r_reg.pg)
		else $error("power good dropped without cause");
	pg_od_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!power_good_output_o && (power_good_output_oe || r_reg.st == pss_pkg::ST_ON))
		else $error("power good driven high or released early");
	flt_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r_reg.st == pss_pkg::ST_FLT && r_reg.en2 &&
		!(r_reg.flt_ot && r_reg.ctrl[`PSS_CTRL_OT_HIC]) &&
		!(r_reg.flt_ov && r_reg.ctrl[`PSS_CTRL_OV_HIC]) |=> r_reg.st == pss_pkg::ST_FLT)
		else $error("fault left without restart mode");
	seq_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r_reg.st == pss_pkg::ST_DLY && r_reg.en2 |=>
		chan_en == '0 || $countones(chan_en ^ $past(chan_en)) <= 1)
		else $error("more than one channel switched at once");
	ot_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r_reg.st == pss_pkg::ST_FLT && r_reg.flt_ot && r_reg.ctrl[`PSS_CTRL_OT_HIC] &&
		!r_reg.ot2 |=> r_reg.st == pss_pkg::ST_OFF && !r_reg.flt_ot)
		else $error("over-temperature restart not taken");
	ov_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		r_reg.st == pss_pkg::ST_FLT && r_reg.flt_ov && r_reg.ctrl[`PSS_CTRL_OV_HIC] &&
		!r_reg.ov2 |=> r_reg.st == pss_pkg::ST_OFF && !r_reg.flt_ov)
		else $error("over-voltage restart not taken");
endmodule // pss_top

// ===== tb/pss_chan_model.sv
// Purpose: Analog channel side: reports 90 percent a while after each enable.
// Assumes: Channel good drops at once when its enable goes low.
// Notes: Slow mode stretches the ramp to test a late last channel.
`timescale 1ns/1ps
module pss_chan_model #(
	parameter int NCH = 5
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Channel side
	input wire logic [NCH-1:0] chan_en,
	input wire logic slow,
	output logic [NCH-1:0] chan_good
);
	int cnt [NCH];
	always @(posedge core_clk) begin
		for (int i = 0; i < NCH; i++) begin
			if (!rst_n || !chan_en[i]) begin
				cnt[i] <= 0;
				chan_good[i] <= 1'b0;
			end else if (cnt[i] < (slow ? 40 : 4)) begin
				cnt[i] <= cnt[i] + 1;
			end else begin
				chan_good[i] <= 1'b1;
			end
		end
	end
endmodule // pss_chan_model

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the power sequence supervisor.
// Assumes: Short calibration, over-voltage and power-good counts.
// Notes: Timing registers 1..4 are zeroed so reruns stay short.
`timescale 1ns/1ps
`include "pss_defs.svh"
module tb_top;
	localparam int NCH = 5;
	localparam int TK = `PSS_TICK_CYC;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	logic chip_enable_pin = 1'b0;
	logic sequence_select_pin = 1'b1;
	logic overtemp_trip = 1'b0;
	logic overvolt_trip = 1'b0;
	logic slow = 1'b0;
	logic [NCH-1:0] chan_good;
	logic [NCH-1:0] chan_en;
	logic power_good_output_o;
	logic power_good_output_oe;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q [$];
	logic [31:0] rnd = 32'hDFF2184F;
	int err_count = 0;
	int samples_checked = 0;
	int n;
	pss_top #(.NCH(NCH), .CAL_TICKS(5), .OV_TICKS(10), .PG_TICKS(20)) u_pss_top (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.chip_enable_pin(chip_enable_pin), .sequence_select_pin(sequence_select_pin),
		.overtemp_trip(overtemp_trip), .overvolt_trip(overvolt_trip),
		.chan_good(chan_good), .chan_en(chan_en), .power_good_output_o(power_good_output_o),
		.power_good_output_oe(power_good_output_oe));
	pss_chan_model #(.NCH(NCH)) u_pss_chan_model (.core_clk(core_clk), .rst_n(rst_n),
		.chan_en(chan_en), .slow(slow), .chan_good(chan_good));
	initial forever #4 core_clk = ~core_clk;
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_seen <= reg_rd;
		if (rd_seen) begin
			chk(reg_rdata, exp_q.pop_front());
		end
	end
	task automatic wait_chan(input int lim);
		logic [NCH-1:0] was;
		was = chan_en;
		n = 0;
		while (n < lim && chan_en === was) begin
			@(posedge core_clk);
			n++;
		end
	endtask
	task automatic order_check(input logic desc);
		logic [NCH-1:0] e;
		e = '0;
		for (int k = 0; k < NCH; k++) begin
			e[desc ? NCH - 1 - k : k] = 1'b1;
			wait_chan(14000);
			chk(32'(chan_en), 32'(e));
			if (k == 0) chk(32'(n >= 99 * TK && n <= 100 * TK + 20), 1);
		end
		chk(32'(power_good_output_oe), 1);
	endtask
	task automatic pg_wait();
		n = 0;
		while (n < 3000 && power_good_output_oe !== 1'b0) begin
			@(posedge core_clk);
			n++;
		end
		chk(32'(n >= 19 * TK && n <= 21 * TK + 60), 1);
		chk(32'(power_good_output_o), 0);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		err_count++;
		$display("unexpected at %0t: watchdog", $time);
		wrap_up();
	end
	// ==========================================
	// Tests
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		wr(`PSS_CTRL_OFS, 32'h3);
		rd(`PSS_CTRL_OFS, 32'h0);
		rd(`PSS_STATE_OFS, 32'h0);
		rd(`PSS_MASK_OFS, 32'h0);
		rd(`PSS_TIM_OFS, 32'h1);
		rd(8'h40, 32'h0);
		repeat (5 * TK + 40) @(posedge core_clk);
		rd(`PSS_STATE_OFS, 32'h200);
		wr(`PSS_CTRL_OFS, 32'h3);
		wr(`PSS_MASK_OFS, 32'h7);
		for (int k = 1; k < `PSS_TIM_NUM; k++) begin
			rnd = xs(rnd);
			wr(`PSS_TIM_OFS + 8'(4 * k), (k < NCH) ? 32'h0 : rnd);
			rd(`PSS_TIM_OFS + 8'(4 * k), (k < NCH) ? 32'h0 : {24'h0, rnd[7:0]});
		end
		$display("test defaults done");
		chip_enable_pin <= 1'b1;
		order_check(1'b1);
		pg_wait();
		chk(32'(irq), 1);
		rd(`PSS_STATE_OFS, 32'hCA1F);
		wr(`PSS_IRQ_OFS, 32'h4);
		chk(32'(irq), 0);
		$display("test sequence done");
		overtemp_trip <= 1'b1;
		wait_chan(10);
		chk(32'(chan_en), 0);
		chk(32'(power_good_output_oe), 1);
		rd(`PSS_IRQ_OFS, 32'h1);
		wr(`PSS_MASK_OFS, 32'h6);
		chk(32'(irq), 0);
		wr(`PSS_MASK_OFS, 32'h7);
		chk(32'(irq), 1);
		sequence_select_pin <= 1'b0;
		slow <= 1'b1;
		overtemp_trip <= 1'b0;
		wr(`PSS_IRQ_OFS, 32'h1);
		chk(32'(irq), 0);
		order_check(1'b0);
		// Slow ramp makes the last channel late to report good
		pg_wait();
		slow <= 1'b0;
		wr(`PSS_IRQ_OFS, 32'h4);
		$display("test overtemp done");
		overvolt_trip <= 1'b1;
		repeat (5 * TK) @(posedge core_clk);
		overvolt_trip <= 1'b0;
		repeat (10) @(posedge core_clk);
		chk(32'(chan_en), 32'h1F);
		chk(32'(power_good_output_oe), 0);
		wr(`PSS_CTRL_OFS, 32'h1);
		overvolt_trip <= 1'b1;
		wait_chan(2000);
		chk(32'(n >= 9 * TK && n <= 11 * TK + 20), 1);
		chk(32'(chan_en), 0);
		chk(32'(power_good_output_oe), 1);
		rd(`PSS_IRQ_OFS, 32'h2);
		overvolt_trip <= 1'b0;
		repeat (300) @(posedge core_clk);
		chk(32'(chan_en), 0);
		wr(`PSS_IRQ_OFS, 32'h2);
		// Turning restart on with the input already low reruns the sequence
		wr(`PSS_CTRL_OFS, 32'h3);
		order_check(1'b0);
		chip_enable_pin <= 1'b0;
		repeat (10) @(posedge core_clk);
		chip_enable_pin <= 1'b1;
		order_check(1'b0);
		pg_wait();
		chip_enable_pin <= 1'b0;
		wait_chan(10);
		chk(32'(chan_en), 0);
		@(posedge core_clk);
		chk(32'(power_good_output_oe), 1);
		$display("test overvolt and enable done");
		wr(`PSS_CTRL_OFS, 32'h3);
		rst_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		chk(32'(irq), 0);
		rst_n <= 1'b1;
		rd(`PSS_CTRL_OFS, 32'h0);
		rd(`PSS_MASK_OFS, 32'h0);
		rd(`PSS_TIM_OFS + 8'h04, 32'h1);
		repeat (3) @(posedge core_clk);
		$display("test reset done");
		wrap_up();
	end
endmodule // tb_top
